// file: core/hfs_fifo_status.sv
// hfs_fifo_status: hdlc transmit/receive fifo status logic, axi4-lite slave
// Functional notes
// - empty transmit fifo without end: abort, underrun
// - receive data shown by pool-full or message-end
// - unserved within 2 ms sets overflow in the receive status byte
// - sync clear: interrupts raised independently
// - sync set: interrupt only with rx and tx
// - first block announced by pool-full interrupt
// - discard drops remaining bytes until frame end
// - after discard, next status is next frame
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
module hfs_fifo_status #(
  parameter int RX_DEPTH = 64,
  parameter int TX_DEPTH = 64,
  parameter int RX_BLOCK = 32,
  parameter int SERVICE_CYCLES = hfs_pkg::SERVICE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_clk,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic [7:0] rx_byte,
  input wire logic tx_pull,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic tx_end,
  output logic tx_abort,
  output logic irq
);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam int SVW = $clog2(SERVICE_CYCLES + 1);
  localparam logic [SVW-1:0] SVC_LAST = SVW'(SERVICE_CYCLES - 1);
  localparam logic [RAW:0] RX_FULL = (RAW+1)'(RX_DEPTH);
  localparam logic [RAW:0] RX_DATA_MAX = (RAW+1)'(RX_DEPTH - 1);
  localparam logic [TAW:0] TX_FULL = (TAW+1)'(TX_DEPTH);
  localparam logic [RAW:0] BLK_LAST = (RAW+1)'(RX_BLOCK - 1);

  if (RX_BLOCK < 2 || RX_BLOCK >= RX_DEPTH || SERVICE_CYCLES < 2)
  begin : g_chk
    $error("hfs_fifo_status: RX_BLOCK or SERVICE_CYCLES out of range");
  end

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = a == hfs_pkg::ADDR_STATUS || a == hfs_pkg::ADDR_MASK ||
      a == hfs_pkg::ADDR_CTRL || a == hfs_pkg::ADDR_CMD ||
      a == hfs_pkg::ADDR_TX_DATA || a == hfs_pkg::ADDR_RX_DATA ||
      a == hfs_pkg::ADDR_LEVEL;
  endfunction

  // ==========================================================
  // link synchronisers; data is taken at the sampled link clock rise
  logic [11:0] lk_s1;
  logic [11:0] lk_s2;
  logic lk_prev;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lk_s1 <= 12'h000;
      lk_s2 <= 12'h000;
      lk_prev <= 1'b0;
    end
    else
    begin
      lk_s1 <= {link_clk, rx_valid, rx_end, tx_pull, rx_byte};
      lk_s2 <= lk_s1;
      lk_prev <= lk_s2[11];
    end
  end
  logic lk_rise;
  logic rx_beat;
  logic rx_fin;
  logic tx_beat;
  assign lk_rise = lk_s2[11] && !lk_prev;
  assign rx_beat = lk_rise && lk_s2[10] && !lk_s2[9];
  assign rx_fin = lk_rise && lk_s2[9];
  assign tx_beat = lk_rise && lk_s2[8];

  // ==========================================================
  // axi4-lite write channel
  logic aw_have;
  logic w_have;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic do_write;
  logic wr_en;
  assign do_write = aw_have && w_have && !s_axi_bvalid;
  assign wr_en = do_write && w_lane0;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= hfs_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (do_write)
      begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      else if (do_write)
      begin
        w_have <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_addr) ? hfs_pkg::RESP_OKAY :
          hfs_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  logic cmd_wr;
  logic cmd_xtf;
  logic cmd_xme;
  logic cmd_rmd;
  logic cmd_rrel;
  assign cmd_wr = wr_en && aw_addr == hfs_pkg::ADDR_CMD;
  assign cmd_xtf = cmd_wr && w_data[hfs_pkg::CMD_XTF];
  assign cmd_xme = cmd_wr && w_data[hfs_pkg::CMD_XME];
  assign cmd_rmd = cmd_wr && w_data[hfs_pkg::CMD_RMD];
  assign cmd_rrel = cmd_wr && w_data[hfs_pkg::CMD_RREL];

  // ==========================================================
  // receive path
  logic [RAW-1:0] rx_wr_ptr;
  logic [RAW-1:0] rx_rd_ptr;
  logic [RAW:0] rx_count;
  logic [RAW:0] rx_blk;
  logic [7:0] rx_rdata;
  logic rx_ovf;
  logic rx_discard;
  logic rx_had_rpf;
  logic svc_pending;
  logic [SVW-1:0] svc_timer;
  logic rx_pop;
  logic rx_push_data;
  logic rx_push_sta;
  logic rx_we;
  logic [7:0] rx_wdata;
  logic rpf_evt;
  logic svc_late;

  // one slot stays free so the status byte fits unless the fifo is already full
  assign rx_push_data = rx_beat && !rx_discard && !cmd_rmd && !rx_ovf &&
    rx_count < RX_DATA_MAX;
  assign rx_push_sta = rx_fin && !rx_discard && !cmd_rmd &&
    rx_count != RX_FULL;
  assign rx_we = rx_push_data || rx_push_sta;
  assign rx_wdata = rx_push_sta ? 8'(rx_ovf) << hfs_pkg::RECEIVE_STATUS_BYTE_RDO :
    lk_s2[7:0];
  assign rpf_evt = rx_push_data && rx_blk == BLK_LAST;
  assign svc_late = svc_pending && svc_timer == SVC_LAST;

  hfs_mem #(.W(8), .DEPTH(RX_DEPTH)) u_rx_mem (
    .clk(clk),
    .we(rx_we),
    .waddr(rx_wr_ptr),
    .wdata(rx_wdata),
    .raddr(rx_rd_ptr),
    .rdata(rx_rdata)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count <= '0;
      rx_blk <= '0;
    end
    else
    begin
      if (rx_we)
      begin
        rx_wr_ptr <= rx_wr_ptr + 1'b1;
      end
      if (cmd_rmd)
      begin
        // flush every unread byte, those of earlier frames as well as of the dropped one
        rx_rd_ptr <= rx_wr_ptr;
        rx_count <= '0;
        rx_blk <= '0;
      end
      else
      begin
        if (rx_pop)
        begin
          rx_rd_ptr <= rx_rd_ptr + 1'b1;
        end
        rx_count <= rx_count + (RAW+1)'(rx_we) - (RAW+1)'(rx_pop);
        if (rpf_evt || rx_push_sta)
        begin
          rx_blk <= '0;
        end
        else if (rx_push_data)
        begin
          rx_blk <= rx_blk + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_ovf <= 1'b0;
      rx_discard <= 1'b0;
      rx_had_rpf <= 1'b0;
    end
    else
    begin
      // a late service marks the frame now being received
      if (svc_late || (rx_beat && !rx_discard && !rx_push_data && !cmd_rmd))
      begin
        rx_ovf <= 1'b1;
      end
      else if (rx_push_sta || cmd_rmd)
      begin
        rx_ovf <= 1'b0;
      end
      if (rx_fin)
      begin
        rx_discard <= 1'b0;
      end
      else if (cmd_rmd)
      begin
        rx_discard <= 1'b1;
      end
      if (rpf_evt)
      begin
        rx_had_rpf <= 1'b1;
      end
      else if (rx_push_sta || cmd_rmd)
      begin
        rx_had_rpf <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      svc_pending <= 1'b0;
      svc_timer <= '0;
    end
    else if (rpf_evt || rx_push_sta)
    begin
      svc_pending <= 1'b1;
      svc_timer <= '0;
    end
    else if (cmd_rrel || cmd_rmd || svc_late)
    begin
      svc_pending <= 1'b0;
    end
    else if (svc_pending)
    begin
      svc_timer <= svc_timer + 1'b1;
    end
  end

  // ==========================================================
  // transmit path
  logic [TAW-1:0] tx_wr_ptr;
  logic [TAW-1:0] tx_rd_ptr;
  logic [TAW:0] tx_count;
  logic [7:0] tx_rdata;
  logic tx_active;
  logic tx_me;
  logic tx_push;
  logic tx_pop;
  logic tx_starve;
  logic xpr_evt;
  logic xdu_evt;
  assign tx_push = wr_en && aw_addr == hfs_pkg::ADDR_TX_DATA &&
    tx_count != TX_FULL;
  assign tx_pop = tx_beat && tx_active && tx_count != '0;
  assign tx_starve = tx_beat && tx_active && tx_count == '0;
  assign xpr_evt = (tx_pop && tx_count == (TAW+1)'(1) && !tx_push &&
    !tx_me) || (tx_starve && tx_me);
  assign xdu_evt = tx_starve && !tx_me;

  hfs_mem #(.W(8), .DEPTH(TX_DEPTH)) u_tx_mem (
    .clk(clk),
    .we(tx_push),
    .waddr(tx_wr_ptr),
    .wdata(w_data[7:0]),
    .raddr(tx_rd_ptr),
    .rdata(tx_rdata)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_wr_ptr <= '0;
      tx_rd_ptr <= '0;
      tx_count <= '0;
    end
    else
    begin
      if (tx_push)
      begin
        tx_wr_ptr <= tx_wr_ptr + 1'b1;
      end
      if (tx_pop)
      begin
        tx_rd_ptr <= tx_rd_ptr + 1'b1;
      end
      tx_count <= tx_count + (TAW+1)'(tx_push) - (TAW+1)'(tx_pop);
    end
  end

  // link outputs hold for a whole link period, updated at each pull
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_active <= 1'b0;
      tx_me <= 1'b0;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      tx_end <= 1'b0;
      tx_abort <= 1'b0;
    end
    else
    begin
      if (tx_beat)
      begin
        tx_byte <= tx_pop ? tx_rdata : 8'h00;
        tx_valid <= tx_pop;
        tx_end <= tx_starve && tx_me;
        tx_abort <= xdu_evt;
      end
      if (tx_starve)
      begin
        tx_active <= 1'b0;
        tx_me <= 1'b0;
      end
      else
      begin
        if (cmd_xtf)
        begin
          tx_active <= 1'b1;
        end
        if (cmd_xme)
        begin
          tx_me <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // status, mask, control and interrupt
  logic [3:0] status;
  logic [3:0] mask;
  logic interrupt_sync_enable;
  logic [3:0] st_set;
  logic [3:0] st_clr;
  logic [3:0] st_live;
  assign st_set = {xdu_evt, xpr_evt, rx_push_sta, rpf_evt};
  assign st_clr = (wr_en && aw_addr == hfs_pkg::ADDR_STATUS ?
    w_data[3:0] : 4'h0) | (cmd_rmd ? hfs_pkg::ST_RX_BITS : 4'h0);
  assign st_live = status & ~mask;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status <= hfs_pkg::STATUS_RST;
      mask <= hfs_pkg::MASK_RST;
      interrupt_sync_enable <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      // set wins over a clear in the same cycle
      status <= (status & ~st_clr) | st_set;
      if (wr_en && aw_addr == hfs_pkg::ADDR_MASK)
      begin
        mask <= w_data[3:0];
      end
      if (wr_en && aw_addr == hfs_pkg::ADDR_CTRL)
      begin
        interrupt_sync_enable <= w_data[hfs_pkg::CTRL_INTERRUPT_SYNC_ENABLE];
      end
      irq <= interrupt_sync_enable ? (|(st_live & hfs_pkg::ST_RX_BITS)) &&
        (|(st_live & hfs_pkg::ST_TX_BITS)) : |st_live;
    end
  end

  // ==========================================================
  // axi4-lite read channel
  hfs_pkg::hfs_rd_e rd_state;
  logic [11:0] ar_addr;
  logic rd_pop;
  logic [31:0] rd_value;
  assign rx_pop = rd_state == hfs_pkg::RD_RESP && s_axi_rready && rd_pop &&
    rx_count != '0;

  always_comb
  begin
    unique case (ar_addr)
      hfs_pkg::ADDR_STATUS: rd_value = 32'(status);
      hfs_pkg::ADDR_MASK: rd_value = 32'(mask);
      hfs_pkg::ADDR_CTRL: rd_value = 32'(interrupt_sync_enable);
      hfs_pkg::ADDR_RX_DATA: rd_value = 32'(rx_rdata);
      hfs_pkg::ADDR_LEVEL: rd_value = {16'(tx_count), 16'(rx_count)};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_state <= hfs_pkg::RD_IDLE;
      ar_addr <= 12'h000;
      rd_pop <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= hfs_pkg::RESP_OKAY;
    end
    else
    begin
      unique case (rd_state)
        hfs_pkg::RD_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            ar_addr <= s_axi_araddr;
            s_axi_arready <= 1'b0;
            rd_state <= hfs_pkg::RD_WAIT;
          end
        end
        hfs_pkg::RD_WAIT:
        begin
          s_axi_rdata <= rd_value;
          s_axi_rresp <= addr_mapped(ar_addr) ? hfs_pkg::RESP_OKAY :
            hfs_pkg::RESP_SLVERR;
          s_axi_rvalid <= 1'b1;
          rd_pop <= ar_addr == hfs_pkg::ADDR_RX_DATA && rx_count != '0;
          rd_state <= hfs_pkg::RD_RESP;
        end
        hfs_pkg::RD_RESP:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_state <= hfs_pkg::RD_IDLE;
          end
        end
        default:
        begin
          rd_state <= hfs_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_starve_open;
    tx_beat && tx_active && tx_count == '0 && !tx_me;
  endsequence
  sequence s_abort_out;
    tx_abort && !tx_active ##1 status[hfs_pkg::ST_XDU];
  endsequence
  AST_UNDERRUN_ABORT: assert property (s_starve_open |=> s_abort_out)
    else $error("underrun did not abort the frame");
  AST_RX_DATA_SHOWN: assert property (rx_push_sta && !rx_had_rpf |=>
    status[hfs_pkg::ST_RME] && rx_count != '0)
    else $error("frame end not shown as message end");
  AST_LATE_SERVICE: assert property (svc_late && !rx_push_sta && !cmd_rmd
    |=> rx_ovf && !svc_pending)
    else $error("late service did not flag overflow");
  AST_RECEIVE_STATUS_BYTE_FLAG: assert property (rx_push_sta |->
    rx_wdata[hfs_pkg::RECEIVE_STATUS_BYTE_RDO] == rx_ovf)
    else $error("status byte overflow bit wrong");
  AST_IRQ_FREE: assert property (!interrupt_sync_enable && st_live != 4'h0 |=> irq)
    else $error("unsynchronised interrupt missing");
  AST_IRQ_SYNC: assert property (interrupt_sync_enable &&
    (st_live & hfs_pkg::ST_TX_BITS) == 4'h0 |=> !irq)
    else $error("synchronised interrupt raised without tx status");
  AST_FIRST_BLOCK: assert property (rpf_evt |=>
    status[hfs_pkg::ST_RPF] && svc_pending && rx_blk == '0)
    else $error("full block not announced");
  AST_DISCARD_DROP: assert property (rx_discard && rx_beat |->
    !rx_we)
    else $error("byte stored while discarding");
  AST_DISCARD_NEXT: assert property (cmd_rmd |=> rx_count == '0 &&
    (status & hfs_pkg::ST_RX_BITS) == 4'h0)
    else $error("discarded frame status still visible");
  AST_SHORT_FRAME: assert property (rx_push_sta && !rx_had_rpf &&
    !status[hfs_pkg::ST_RPF] |=> !status[hfs_pkg::ST_RPF])
    else $error("short frame raised pool full");
endmodule

// file: core/hfs_mem.sv
// hfs_mem: byte memory with one write port and a registered read port
module hfs_mem #(
  parameter int W = 8,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("hfs_mem: DEPTH must be a power of two of at least 4");
  end

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end
endmodule

// file: core/hfs_pkg.sv
// hfs_pkg: constants and types shared by the hdlc fifo status block
package hfs_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int SERVICE_TIME_US = 2000;
  localparam int SERVICE_CYCLES = SERVICE_TIME_US * CLK_MHZ;

  // ==========================================================
  // register byte addresses
  localparam int AXI_AW = 12;
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_MASK = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_CMD = 12'h00c;
  localparam logic [11:0] ADDR_TX_DATA = 12'h010;
  localparam logic [11:0] ADDR_RX_DATA = 12'h014;
  localparam logic [11:0] ADDR_LEVEL = 12'h018;

  // ==========================================================
  // status and mask layout
  localparam int ST_W = 4;
  localparam int ST_RPF = 0;
  localparam int ST_RME = 1;
  localparam int ST_XPR = 2;
  localparam int ST_XDU = 3;
  localparam logic [3:0] ST_RX_BITS = 4'h3;
  localparam logic [3:0] ST_TX_BITS = 4'hc;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  // ==========================================================
  // control and command bits
  localparam int CTRL_INTERRUPT_SYNC_ENABLE = 0;
  localparam int CMD_XTF = 0;
  localparam int CMD_XME = 1;
  localparam int CMD_RMD = 2;
  localparam int CMD_RREL = 3;

  // receive status byte appended after the last data byte
  localparam int RECEIVE_STATUS_BYTE_RDO = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_RESP = 2'b10
  } hfs_rd_e;
endpackage

// file: verif/hfs_fifo_status_tb.sv
// hfs_fifo_status_tb: self-checking bench for the hdlc fifo status block
module hfs_fifo_status_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, reset_n, link_clk, rx_valid, rx_end, tx_pull, irq;
  logic [7:0] rx_byte, tx_byte;
  logic tx_valid, tx_end, tx_abort;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int failures, n_tests, cycles;

  // short block and deadline keep the run brief
  hfs_fifo_status #(.RX_BLOCK(4), .SERVICE_CYCLES(200)) i_hfs_fifo_status (
    .clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_clk(link_clk), .rx_valid(rx_valid), .rx_end(rx_end),
    .rx_byte(rx_byte), .tx_pull(tx_pull), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_end(tx_end), .tx_abort(tx_abort), .irq(irq));

  hfs_host i_hfs_host (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [11:0] a, input logic [31:0] d);
    i_hfs_host.wr(a, d, resp);
  endtask

  task automatic rdm(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    i_hfs_host.rd(a, rv, resp);
    chk(rv & m, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  // one link beat: inputs move while the link clock is low
  task automatic beat(input logic v, input logic e, input logic p,
                      input logic [7:0] b);
    @(posedge clk);
    rx_valid <= v;
    rx_end <= e;
    tx_pull <= p;
    rx_byte <= b;
    repeat (8) @(posedge clk);
    link_clk <= 1'b1;
    repeat (8) @(posedge clk);
    link_clk <= 1'b0;
    {rx_valid, rx_end, tx_pull} <= 3'b000;
  endtask

  task automatic rxf(input int n, input logic [7:0] b0, input logic e);
    for (int i = 0; i < n; i++)
      beat(1'b1, 1'b0, 1'b0, b0 + 8'(i));
    if (e)
      beat(1'b0, 1'b1, 1'b0, 8'h00);
  endtask

  task automatic drain(input logic [7:0] b0, input int n);
    for (int i = 0; i < n; i++)
      rdm(hfs_pkg::ADDR_RX_DATA, 32'hff, 32'(b0 + 8'(i)));
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdm(hfs_pkg::ADDR_STATUS, 32'hf, 32'h0);
    rdm(hfs_pkg::ADDR_MASK, 32'hf, 32'h0);
    rdm(hfs_pkg::ADDR_CTRL, 32'h1, 32'h0);
    chk(32'(irq), 32'h0);
    rdm(12'h01c, 32'hffffffff, 32'h0);
    chk(32'(resp), 32'(hfs_pkg::RESP_SLVERR));
    w(12'h01c, 32'h1);
    chk(32'(resp), 32'(hfs_pkg::RESP_SLVERR));
  endtask

  task automatic t_tx;
    w(hfs_pkg::ADDR_TX_DATA, 32'ha5);
    w(hfs_pkg::ADDR_TX_DATA, 32'h3c);
    w(hfs_pkg::ADDR_CMD, 32'h3);
    chk(32'(resp), 32'(hfs_pkg::RESP_OKAY));
    beat(1'b0, 1'b0, 1'b1, 8'h00);
    chk(32'({tx_valid, tx_end, tx_abort, tx_byte}), 32'h4a5);
    chk(32'(resp), 32'(hfs_pkg::RESP_OKAY));
    beat(1'b0, 1'b0, 1'b1, 8'h00);
    chk(32'({tx_valid, tx_end, tx_abort, tx_byte}), 32'h43c);
    beat(1'b0, 1'b0, 1'b1, 8'h00);
    chk(32'({tx_valid, tx_end, tx_abort}), 32'h2);
    rdm(hfs_pkg::ADDR_STATUS, 32'hc, 32'h4);
    chk(32'(irq), 32'h1);
    w(hfs_pkg::ADDR_STATUS, 32'hf);
    settle;
    chk(32'(irq), 32'h0);
  endtask

  task automatic t_underrun;
    w(hfs_pkg::ADDR_TX_DATA, 32'h77);
    w(hfs_pkg::ADDR_CMD, 32'h1);
    beat(1'b0, 1'b0, 1'b1, 8'h00);
    chk(32'({tx_valid, tx_end, tx_abort, tx_byte}), 32'h477);
    beat(1'b0, 1'b0, 1'b1, 8'h00);
    chk(32'({tx_valid, tx_end, tx_abort}), 32'h1);
    rdm(hfs_pkg::ADDR_STATUS, 32'h8, 32'h8);
    w(hfs_pkg::ADDR_STATUS, 32'hf);
  endtask

  task automatic t_discard;
    rxf(4, 8'h10, 1'b0);
    rdm(hfs_pkg::ADDR_STATUS, 32'h3, 32'h1);
    chk(32'(irq), 32'h1);
    drain(8'h10, 4);
    w(hfs_pkg::ADDR_STATUS, 32'hf);
    w(hfs_pkg::ADDR_CMD, 32'h8);
    rxf(4, 8'h20, 1'b0);
    rdm(hfs_pkg::ADDR_STATUS, 32'h3, 32'h1);
    w(hfs_pkg::ADDR_CMD, 32'h4);
    rxf(3, 8'h24, 1'b1);
    rdm(hfs_pkg::ADDR_STATUS, 32'h3, 32'h0);
    rdm(hfs_pkg::ADDR_LEVEL, 32'hffff, 32'h0);
    rxf(2, 8'h30, 1'b1);
    w(hfs_pkg::ADDR_CMD, 32'h8);
    rdm(hfs_pkg::ADDR_STATUS, 32'h3, 32'h2);
    drain(8'h30, 2);
    rdm(hfs_pkg::ADDR_RX_DATA, 32'hff, 32'h0);
    w(hfs_pkg::ADDR_STATUS, 32'hf);
  endtask

  task automatic t_sync;
    w(hfs_pkg::ADDR_CTRL, 32'h1);
    rxf(1, 8'h40, 1'b1);
    w(hfs_pkg::ADDR_CMD, 32'h8);
    settle;
    chk(32'(irq), 32'h0);
    w(hfs_pkg::ADDR_TX_DATA, 32'h5a);
    w(hfs_pkg::ADDR_CMD, 32'h3);
    beat(1'b0, 1'b0, 1'b1, 8'h00);
    beat(1'b0, 1'b0, 1'b1, 8'h00);
    settle;
    chk(32'(irq), 32'h1);
    w(hfs_pkg::ADDR_CTRL, 32'h0);
    w(hfs_pkg::ADDR_MASK, 32'hf);
    settle;
    chk(32'(irq), 32'h0);
    w(hfs_pkg::ADDR_MASK, 32'h0);
    settle;
    chk(32'(irq), 32'h1);
    w(hfs_pkg::ADDR_STATUS, 32'hf);
    settle;
    chk(32'(irq), 32'h0);
    drain(8'h40, 1);
    rdm(hfs_pkg::ADDR_RX_DATA, 32'hff, 32'h0);
  endtask

  // deadline runs out while the next frame is arriving
  task automatic t_overflow;
    rxf(2, 8'h50, 1'b1);
    rxf(1, 8'h60, 1'b0);
    repeat (250) @(posedge clk);
    rxf(1, 8'h61, 1'b1);
    drain(8'h50, 2);
    rdm(hfs_pkg::ADDR_RX_DATA, 32'hff, 32'h0);
    drain(8'h60, 1);
    rdm(hfs_pkg::ADDR_RX_DATA, 32'hff, 32'h80);
  endtask

  // ==========================================================
  // verdict and main sequence
  task automatic end_sim;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      end_sim;
    end
  end

  initial
  begin
    {failures, n_tests, cycles} = '0;
    {link_clk, rx_valid, rx_end, tx_pull, rx_byte} = '0;
    reset_n = 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_tx;
    t_underrun;
    t_discard;
    t_sync;
    t_overflow;
    end_sim;
  end
endmodule

// file: verif/hfs_host.sv
// hfs_host: axi4-lite host model that reaches the status block registers
module hfs_host (
  input wire logic clk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end

  // ==========================================================
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (!ad && awready)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready)
      begin
        wd = 1;
        wvalid <= 1'b0;
      end
      if (bvalid)
        break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  // ==========================================================
  // read: rready held until the answer is sampled
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit ad;
    ad = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (!ad && arready)
      begin
        ad = 1;
        arvalid <= 1'b0;
      end
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
